// ==== sltx_cfg.svh ====
`ifndef SLTX_CFG_SVH
`define SLTX_CFG_SVH
// APB register byte offsets
`define SLTX_CTRL_OFS     12'h000
`define SLTX_STAT_OFS     12'h004
`define SLTX_ERR_OFS      12'h008
`define SLTX_SBF_OFS      12'h00c
`define SLTX_GAP_OFS      12'h010
`define SLTX_ID_OFS       12'h014
// Control fields
`define SLTX_CTRL_ADV     0
`define SLTX_CTRL_BURST   1
`define SLTX_CTRL_ECC     2
`define SLTX_CTRL_ALTTILE 3
`define SLTX_CTRL_MRST    4
// Status fields
`define SLTX_ST_LINK      0
`define SLTX_ST_ACCEPT    1
`define SLTX_ST_URST      2
`define SLTX_ST_IRST      3
`define SLTX_ST_LOCK      4
`define SLTX_ST_TXRDY     5
// Error bits
`define SLTX_ERR_OVF      0
`define SLTX_ERR_SEC      1
`define SLTX_ERR_DED      2
`define SLTX_ERR_GAP      3
// Reset values
`define SLTX_CTRL_RST     32'h0000_0012
`define SLTX_GAP_RST      16'h0004
// Arbitrary identification value
`define SLTX_ID_VAL       32'h5a5a_0001
// Reset sequence length in ns and derived cycles at 40 MHz
`define SLTX_SEQ_NS       400
`define SLTX_CLK_NS       25
`define SLTX_SEQ_CYC      ((`SLTX_SEQ_NS + `SLTX_CLK_NS - 1) / `SLTX_CLK_NS)
`endif

// ==== sltx_pkg.sv ====
package sltx_pkg;
    typedef enum logic [1:0]
    {
        SLTX_IDLE  = 2'b00,
        SLTX_BURST = 2'b01,
        SLTX_GAP   = 2'b10
    } sltx_bst_t;
    typedef enum logic [1:0]
    {
        SLTX_RST  = 2'b00,
        SLTX_SEQ  = 2'b01,
        SLTX_UP   = 2'b10
    } sltx_rst_t;
endpackage

// ==== sltx_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// Source adaptation FIFO: registered read data, honest full/empty
module sltx_fifo #(
    parameter int W     = 74,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clr,
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_en,
    output logic      [W-1:0]  rd_data,
    output logic      [AW:0]   level,
    output logic               full,
    output logic               empty
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic          do_wr;
    logic          do_rd;

    initial
    begin
        if (DEPTH != (1 << AW))
            $error("sltx_fifo: DEPTH must equal 2**AW");
    end

    assign full  = (level == (AW+1)'(DEPTH));
    assign empty = (level == '0);
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;

    // Storage array
    always_ff @(posedge pclk)
    begin
        if (do_wr)
            mem[wp_r] <= wr_data;
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data <= '0;
        else if (do_rd)
            rd_data <= mem[rp_r];
    end

    // Pointers and fill level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            level <= '0;
        end
        else if (clr)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            level <= '0;
        end
        else
        begin
            if (do_wr)
                wp_r <= wp_r + 1'b1;
            if (do_rd)
                rp_r <= rp_r + 1'b1;
            if (do_wr && !do_rd)
                level <= level + 1'b1;
            else if (do_rd && !do_wr)
                level <= level - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== sltx_core.sv ====
`include "sltx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sltx_core #(
    parameter int LANES = 2,
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int AFULL = 4
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [LANES-1:0]    tx_serial_clk,
    input  wire logic                tx_pll_locked,
    input  wire logic                phy_tx_ready,
    input  wire logic                user_reset_in,
    input  wire logic                seu_corrected,
    input  wire logic                seu_uncorrected,
    input  wire logic [64*LANES-1:0] data_tx,
    input  wire logic [7:0]          sync_tx,
    input  wire logic                valid_tx,
    input  wire logic                burst_first_flag,
    input  wire logic                burst_last_flag,
    input  wire logic                link_rd,
    output logic      [64*LANES-1:0] link_data,
    output logic                     link_valid,
    output logic [7:0]               link_sb_first,
    output logic [7:0]               link_sb_last,
    output logic                     user_reset_out,
    output logic                     intf_reset_out,
    output logic                     link_up_tx,
    output logic                     tx_accept,
    output logic      [3:0]          error_tx
);
    localparam int W = 64*LANES + 2;

    logic [31:0]          ctrl_r;
    logic [15:0]          gap_r;
    logic [3:0]           err_r;
    logic [7:0]           sbf_r;
    logic [7:0]           sbl_r;
    logic [1:0]           lock_s_r;
    logic [1:0]           rdy_s_r;
    logic [1:0]           ur_s_r;
    logic [LANES-1:0]     sclk_s1_r;
    logic [LANES-1:0]     sclk_s2_r;
    logic [LANES-1:0]     sclk_s3_r;
    logic [LANES-1:0]     sclk_seen_r;
    sltx_pkg::sltx_rst_t  rst_st_r;
    logic [7:0]           seq_cnt_r;
    sltx_pkg::sltx_bst_t  bst_r;
    logic [15:0]          gap_cnt_r;
    logic                 link_up_r;
    logic                 fifo_full;
    logic                 fifo_empty;
    logic [AW:0]          fifo_level;
    logic [W-1:0]         fifo_rd;
    logic                 adv;
    logic                 alt;
    logic                 phy_ok;
    logic                 wr_acc;
    logic                 push;
    logic                 first_w;
    logic                 pop;

    initial
    begin
        if (LANES < 1 || LANES > 32)
            $error("sltx_core: LANES out of range");
        if (AFULL < 1 || AFULL >= DEPTH)
            $error("sltx_core: AFULL out of range");
    end

    assign adv    = ctrl_r[`SLTX_CTRL_ADV];
    assign alt    = ctrl_r[`SLTX_CTRL_ALTTILE];
    // Lock and serial clocks only count on the standard tile
    assign phy_ok = rdy_s_r[1] &&
                    (alt || (lock_s_r[1] && (&sclk_seen_r)));
    assign wr_acc = psel && penable && pwrite;

    // Synchronisers for asynchronous pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_s_r  <= '0;
            rdy_s_r   <= '0;
            ur_s_r    <= '0;
            sclk_s1_r <= '0;
            sclk_s2_r <= '0;
            sclk_s3_r <= '0;
        end
        else
        begin
            lock_s_r  <= {lock_s_r[0], tx_pll_locked};
            rdy_s_r   <= {rdy_s_r[0], phy_tx_ready};
            ur_s_r    <= {ur_s_r[0], user_reset_in};
            sclk_s1_r <= tx_serial_clk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
        end
    end

    // Per-lane serial clock activity, cleared by management reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sclk_seen_r <= '0;
        else if (ctrl_r[`SLTX_CTRL_MRST])
            sclk_seen_r <= '0;
        else
            sclk_seen_r <= sclk_seen_r | (sclk_s2_r & ~sclk_s3_r);
    end

    // Reset sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_st_r  <= sltx_pkg::SLTX_RST;
            seq_cnt_r <= '0;
        end
        else if (ctrl_r[`SLTX_CTRL_MRST] || !phy_ok)
        begin
            rst_st_r  <= sltx_pkg::SLTX_RST;
            seq_cnt_r <= '0;
        end
        else
        begin
            unique case (rst_st_r)
                sltx_pkg::SLTX_RST:
                    rst_st_r <= sltx_pkg::SLTX_SEQ;
                sltx_pkg::SLTX_SEQ:
                begin
                    if (seq_cnt_r == 8'(`SLTX_SEQ_CYC - 1))
                        rst_st_r <= sltx_pkg::SLTX_UP;
                    else
                        seq_cnt_r <= seq_cnt_r + 8'h01;
                end
                sltx_pkg::SLTX_UP:
                    rst_st_r <= sltx_pkg::SLTX_UP;
                default:
                    rst_st_r <= sltx_pkg::SLTX_RST;
            endcase
        end
    end

    // Reset outputs per clocking mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            user_reset_out <= 1'b1;
            intf_reset_out <= 1'b1;
        end
        else
        begin
            user_reset_out <= !adv && (rst_st_r != sltx_pkg::SLTX_UP);
            intf_reset_out <= adv && (rst_st_r != sltx_pkg::SLTX_UP);
        end
    end

    // Link-up once sequence done and user domain out of reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link_up_r <= 1'b0;
        else
            link_up_r <= (rst_st_r == sltx_pkg::SLTX_UP) &&
                         !(adv && ur_s_r[1]);
    end
    assign link_up_tx = link_up_r;

    // Accept: combinational handshake
    assign tx_accept = link_up_r &&
                       (fifo_level < (AW+1)'(DEPTH - AFULL));

    // Words are only stored while linked up
    assign push = valid_tx && link_up_r;

    // Burst tracking and gap check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bst_r     <= sltx_pkg::SLTX_IDLE;
            gap_cnt_r <= '0;
        end
        else if (!link_up_r)
        begin
            bst_r     <= sltx_pkg::SLTX_IDLE;
            gap_cnt_r <= '0;
        end
        else
        begin
            unique case (bst_r)
                sltx_pkg::SLTX_IDLE:
                    if (push && burst_first_flag)
                        bst_r <= (burst_last_flag &&
                                  ctrl_r[`SLTX_CTRL_BURST]) ?
                                 sltx_pkg::SLTX_GAP : sltx_pkg::SLTX_BURST;
                sltx_pkg::SLTX_BURST:
                begin
                    gap_cnt_r <= '0;
                    if (push && burst_last_flag &&
                        ctrl_r[`SLTX_CTRL_BURST])
                        bst_r <= sltx_pkg::SLTX_GAP;
                end
                sltx_pkg::SLTX_GAP:
                begin
                    if (push && burst_first_flag)
                    begin
                        // A one-word burst goes straight back to the gap
                        gap_cnt_r <= '0;
                        bst_r     <= (burst_last_flag &&
                                      ctrl_r[`SLTX_CTRL_BURST]) ?
                                     sltx_pkg::SLTX_GAP : sltx_pkg::SLTX_BURST;
                    end
                    else if (gap_cnt_r != 16'hffff)
                        gap_cnt_r <= gap_cnt_r + 16'h0001;
                end
                default:
                    bst_r <= sltx_pkg::SLTX_IDLE;
            endcase
        end
    end

    assign first_w = push && burst_first_flag;

    // Sideband capture on first and last words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sbf_r <= '0;
            sbl_r <= '0;
        end
        else
        begin
            if (first_w)
                sbf_r <= sync_tx;
            if (push && burst_last_flag)
                sbl_r <= sync_tx;
        end
    end

    // Source adaptation FIFO carries data with first/last marks
    sltx_fifo #(
        .W     (W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!link_up_r),
        .wr_en   (push),
        .wr_data ({burst_last_flag, burst_first_flag, data_tx}),
        .rd_en   (pop),
        .rd_data (fifo_rd),
        .level   (fifo_level),
        .full    (fifo_full),
        .empty   (fifo_empty)
    );

    assign pop = link_rd && !fifo_empty;

    // Link side output register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link_valid <= 1'b0;
        else
            link_valid <= pop;
    end
    assign link_data     = fifo_rd[64*LANES-1:0];
    assign link_sb_first = sbf_r;
    assign link_sb_last  = sbl_r;

    // Sticky error bits; set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_r <= '0;
        else
        begin
            err_r <= (wr_acc && paddr == `SLTX_ERR_OFS) ?
                     (err_r & ~pwdata[3:0]) : err_r;
            if (push && fifo_full && !pop)
                err_r[`SLTX_ERR_OVF] <= 1'b1;
            if (ctrl_r[`SLTX_CTRL_ECC] && seu_corrected)
                err_r[`SLTX_ERR_SEC] <= 1'b1;
            if (ctrl_r[`SLTX_CTRL_ECC] && seu_uncorrected)
                err_r[`SLTX_ERR_DED] <= 1'b1;
            if (bst_r == sltx_pkg::SLTX_GAP && first_w &&
                gap_cnt_r != gap_r)
                err_r[`SLTX_ERR_GAP] <= 1'b1;
        end
    end
    assign error_tx = err_r;

    // APB register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= `SLTX_CTRL_RST;
            gap_r  <= `SLTX_GAP_RST;
        end
        else if (wr_acc)
        begin
            if (paddr == `SLTX_CTRL_OFS)
                ctrl_r <= {27'h0, pwdata[4:0]};
            if (paddr == `SLTX_GAP_OFS)
                gap_r <= pwdata[15:0];
        end
    end

    // APB read data, zero-wait answer
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     !(paddr == `SLTX_CTRL_OFS || paddr == `SLTX_STAT_OFS ||
                       paddr == `SLTX_ERR_OFS || paddr == `SLTX_SBF_OFS ||
                       paddr == `SLTX_GAP_OFS || paddr == `SLTX_ID_OFS);
    always_comb
    begin
        prdata = '0;
        if (psel && !pwrite)
        begin
            unique case (paddr)
                `SLTX_CTRL_OFS: prdata = ctrl_r;
                `SLTX_STAT_OFS: prdata = {26'h0, rdy_s_r[1], lock_s_r[1],
                                          intf_reset_out, user_reset_out,
                                          tx_accept, link_up_r};
                `SLTX_ERR_OFS:  prdata = {28'h0, err_r};
                `SLTX_SBF_OFS:  prdata = {16'h0, sbl_r, sbf_r};
                `SLTX_GAP_OFS:  prdata = {16'h0, gap_r};
                `SLTX_ID_OFS:   prdata = `SLTX_ID_VAL;
                default:        prdata = '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== sltx_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the transmit core
module sltx_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       phy_tx_ready,
    input wire logic       seu_corrected,
    input wire logic       seu_uncorrected,
    input wire logic [7:0] sync_tx,
    input wire logic       valid_tx,
    input wire logic       burst_first_flag,
    input wire logic       link_rd,
    input wire logic       link_valid,
    input wire logic [7:0] link_sb_first,
    input wire logic       link_up_tx,
    input wire logic       tx_accept,
    input wire logic [3:0] error_tx
);
    logic [4:0] down_cnt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Cycles spent with the link down, saturating
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            down_cnt <= 5'h00;
        else if (link_up_tx)
            down_cnt <= 5'h00;
        else if (down_cnt != 5'h1f)
            down_cnt <= down_cnt + 5'h01;
    // Steps of the checked cases
    sequence s_first_take;
        valid_tx && burst_first_flag && link_up_tx && tx_accept;
    endsequence
    sequence s_phy_gone;
        !phy_tx_ready [*5];
    endsequence
    property p_acc_link;
        tx_accept |-> link_up_tx;
    endproperty
    property p_phy_drop;
        s_phy_gone |-> !link_up_tx && !tx_accept;
    endproperty
    property p_link_up;
        $rose(link_up_tx) |-> down_cnt >= 5'h10;
    endproperty
    property p_ovf;
        $rose(error_tx[0]) |-> $past(valid_tx && link_up_tx && !tx_accept);
    endproperty
    property p_sec;
        $rose(error_tx[1]) |-> $past(seu_corrected) || $past(seu_corrected, 2);
    endproperty
    property p_ded;
        $rose(error_tx[2]) |-> $past(seu_uncorrected)
            || $past(seu_uncorrected, 2);
    endproperty
    property p_gap;
        $rose(error_tx[3]) |->
            $past(valid_tx && burst_first_flag && link_up_tx);
    endproperty
    property p_sb_first;
        s_first_take |=> link_sb_first == $past(sync_tx);
    endproperty
    property p_pop;
        link_valid |-> $past(link_rd);
    endproperty
    a_acc_link: assert property (p_acc_link)
        else $error("accept high while link down");
    a_phy_drop: assert property (p_phy_drop)
        else $error("link stays up without phy ready");
    a_link_up: assert property (p_link_up)
        else $error("link up before reset sequence");
    a_ovf: assert property (p_ovf)
        else $error("overflow bit without refused push");
    a_sec: assert property (p_sec)
        else $error("corrected bit without event");
    a_ded: assert property (p_ded)
        else $error("uncorrected bit without event");
    a_gap: assert property (p_gap)
        else $error("gap bit outside burst start");
    a_sb_first: assert property (p_sb_first)
        else $error("first sideband not captured");
    a_pop: assert property (p_pop)
        else $error("link word without pop");
endmodule
bind sltx_core sltx_chk sltx_chk_i (.pclk, .presetn, .phy_tx_ready,
    .seu_corrected, .seu_uncorrected, .sync_tx, .valid_tx,
    .burst_first_flag, .link_rd, .link_valid, .link_sb_first,
    .link_up_tx, .tx_accept, .error_tx);
`default_nettype wire

// ==== sltx_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// User logic that sources bursts into the core
module sltx_src #(
    parameter int LANES = 2
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                link_up_tx,
    input  wire logic                tx_accept,
    input  wire logic                start,
    input  wire logic [3:0]          nwords,
    input  wire logic [1:0]          nbursts,
    input  wire logic [3:0]          gap,
    input  wire logic                rude,
    output logic      [64*LANES-1:0] data_tx,
    output logic      [7:0]          sync_tx,
    output logic                     valid_tx,
    output logic                     burst_first_flag,
    output logic                     burst_last_flag,
    output logic                     busy
);
    logic [3:0] rem_r;
    logic [1:0] brem_r;
    logic [3:0] gcnt_r;
    logic       ok;
    logic       hold;
    // Rude mode pushes regardless, to force an overflow
    assign ok = rude || (link_up_tx && tx_accept);
    assign hold = gcnt_r != 4'h0 || (valid_tx && burst_last_flag && gap != 4'h0);
    assign busy = start || rem_r != 4'h0 || hold || valid_tx;
    // Random payload, lanes side by side
    function automatic logic [64*LANES-1:0] rnd();
        logic [64*LANES-1:0] d;
        for (int i = 0; i < 2*LANES; i++)
            d[32*i +: 32] = $urandom;
        return d;
    endfunction
    // Word sequencing with the idle gap between bursts
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            rem_r            <= 4'h0;
            brem_r           <= 2'h0;
            gcnt_r           <= 4'h0;
            valid_tx         <= 1'b0;
            burst_first_flag <= 1'b0;
            burst_last_flag  <= 1'b0;
            data_tx          <= '0;
            sync_tx          <= 8'h00;
        end
        else
        begin
            if (start)
            begin
                rem_r  <= nwords;
                brem_r <= nbursts;
            end
            if (valid_tx && burst_last_flag && gap != 4'h0)
                gcnt_r <= gap - 4'h1;
            else if (gcnt_r != 4'h0)
                gcnt_r <= gcnt_r - 4'h1;
            if (!start && rem_r != 4'h0 && !hold && ok)
            begin
                valid_tx         <= 1'b1;
                burst_first_flag <= rem_r == nwords;
                burst_last_flag  <= rem_r == 4'h1;
                data_tx          <= rnd();
                sync_tx          <= rem_r == 4'h1 ?
                    8'($urandom_range(LANES-1)) : 8'($urandom);
                if (rem_r == 4'h1 && brem_r > 2'h1)
                begin
                    rem_r  <= nwords;
                    brem_r <= brem_r - 2'h1;
                end
                else
                    rem_r <= rem_r - 4'h1;
            end
            else
            begin
                valid_tx         <= 1'b0;
                burst_first_flag <= 1'b0;
                burst_last_flag  <= 1'b0;
                data_tx          <= ~data_tx;
                sync_tx          <= ~sync_tx;
            end
        end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sltx_cfg.svh"
// Self-checking bench for the transmit core
module testbench;
    localparam int LANES = 2;
    logic                pclk = 1'b0;
    logic [LANES-1:0]    tx_serial_clk = '0;
    logic                presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                tx_pll_locked, phy_tx_ready, user_reset_in;
    logic                seu_corrected, seu_uncorrected;
    logic [64*LANES-1:0] data_tx, link_data;
    logic [7:0]          sync_tx, link_sb_first, link_sb_last, exp_f, exp_l;
    logic                valid_tx, burst_first_flag, burst_last_flag;
    logic                link_rd, link_valid, user_reset_out, intf_reset_out;
    logic                link_up_tx, tx_accept, start, rude, busy, sb_on, rd_en;
    logic [3:0]          error_tx, nwords, gap;
    logic [1:0]          nbursts;
    int                  err_total, check_count;
    logic [64*LANES-1:0] exp_q[$];

    always #12.5 pclk = ~pclk;
    // Serial clock per lane, offset in phase from the bus clock
    initial
    begin
        #7;
        forever #100 tx_serial_clk = ~tx_serial_clk;
    end

    sltx_core #(.LANES(LANES)) sltx_core_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tx_serial_clk, .tx_pll_locked, .phy_tx_ready, .user_reset_in,
        .seu_corrected, .seu_uncorrected, .data_tx, .sync_tx, .valid_tx,
        .burst_first_flag, .burst_last_flag, .link_rd, .link_data,
        .link_valid, .link_sb_first, .link_sb_last, .user_reset_out,
        .intf_reset_out, .link_up_tx, .tx_accept, .error_tx);
    sltx_src #(.LANES(LANES)) sltx_src_i (.pclk, .presetn, .link_up_tx,
        .tx_accept, .start, .nwords, .nbursts, .gap, .rude, .data_tx,
        .sync_tx, .valid_tx, .burst_first_flag, .burst_last_flag, .busy);

    task end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task tmo();
        err_total++;
        $display("Error %0t: wait timed out", $time);
        end_of_test();
    endtask
    task chk(input logic [64*LANES-1:0] got, input logic [64*LANES-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error land in rd and er
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            tmo();
    endtask
    task wait_up();
        int n;
        n = 0;
        while (link_up_tx !== 1'b1 && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400)
            tmo();
        @(negedge pclk);
    endtask
    // Send a train of bursts and wait until it has drained
    task run(input logic [3:0] nw, input logic [1:0] nb, input logic [3:0] g);
        int n;
        @(posedge pclk);
        nwords <= nw;
        nbursts <= nb;
        gap <= g;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        n = 0;
        while ((busy || exp_q.size() != 0) && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000)
            tmo();
        @(negedge pclk);
    endtask

    // Scoreboard and random link-side pops
    always @(posedge pclk)
    begin
        if (valid_tx && link_up_tx && sb_on)
            exp_q.push_back(data_tx);
        if (valid_tx && link_up_tx && burst_first_flag)
            exp_f = sync_tx;
        if (valid_tx && link_up_tx && burst_last_flag)
            exp_l = sync_tx;
        if (link_valid && sb_on)
            chk(link_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
        link_rd <= rd_en && $urandom_range(3) != 0;
    end

    initial
    begin
        {psel, penable, pwrite, start, rude, sb_on, rd_en} = '0;
        {seu_corrected, seu_uncorrected, user_reset_in, link_rd} = '0;
        {paddr, pwdata, nwords, nbursts, gap} = '0;
        {tx_pll_locked, phy_tx_ready, presetn} = 3'b110;
        err_total = 0;
        check_count = 0;
        void'($urandom(32'h51fa9b39));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(link_up_tx, 0);
        chk(tx_accept, 0);
        chk({user_reset_out, intf_reset_out}, 2'b11);
        apb(0, `SLTX_CTRL_OFS, 0);
        chk(rd, `SLTX_CTRL_RST);
        apb(0, `SLTX_GAP_OFS, 0);
        chk(rd, 32'h4);
        apb(0, 12'h018, 0);
        chk({er, rd}, 33'h1_0000_0000);
        // Leave management reset in standard burst mode
        apb(1, `SLTX_CTRL_OFS, 32'h2);
        wait_up();
        chk(user_reset_out, 0);
        chk(tx_accept, 1);
        sb_on <= 1'b1;
        rd_en <= 1'b1;
        run(4'($urandom_range(1, 6)), 3, 4);
        chk(error_tx, 0);
        apb(0, `SLTX_SBF_OFS, 0);
        chk(rd[15:0], {exp_l, exp_f});
        // Too short a gap between bursts
        run(3, 2, 2);
        chk(error_tx, 4'h8);
        apb(1, `SLTX_ERR_OFS, 32'h8);
        @(negedge pclk);
        chk(error_tx, 0);
        // Upset events with ECC enabled
        apb(1, `SLTX_CTRL_OFS, 32'h6);
        @(posedge pclk);
        seu_corrected <= 1'b1;
        @(posedge pclk);
        seu_corrected <= 1'b0;
        seu_uncorrected <= 1'b1;
        @(posedge pclk);
        seu_uncorrected <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(error_tx, 4'h6);
        apb(1, `SLTX_ERR_OFS, 32'hf);
        // Overflow in advanced mode, then loss of phy ready
        apb(1, `SLTX_CTRL_OFS, 32'h3);
        wait_up();
        rd_en <= 1'b0;
        sb_on <= 1'b0;
        rude <= 1'b1;
        run(15, 2, 0);
        chk(tx_accept, 0);
        chk(error_tx[0], 1);
        @(posedge pclk);
        rude <= 1'b0;
        phy_tx_ready <= 1'b0;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        chk({link_up_tx, tx_accept, intf_reset_out}, 3'b001);
        @(posedge pclk);
        phy_tx_ready <= 1'b1;
        wait_up();
        chk(intf_reset_out, 0);
        // User domain reset from outside in advanced clocking
        user_reset_in <= 1'b1;
        repeat (20) @(posedge pclk);
        @(negedge pclk);
        chk(link_up_tx, 0);
        @(posedge pclk);
        user_reset_in <= 1'b0;
        wait_up();
        exp_q.delete();
        apb(1, `SLTX_ERR_OFS, 32'hf);
        sb_on <= 1'b1;
        rd_en <= 1'b1;
        run(5, 2, 4);
        chk(error_tx, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
